// [sim/drc_partner.sv]
// drc_partner: measurement front-end and transfer-area client stand-in
// assumes one clock shared with the recorder; outputs change on the rising edge
`timescale 1ns/1ps
`default_nettype none
module drc_partner #(
  parameter int AP = 10  // clocks between 64 s/c strobes
) (
  input  wire logic                                        clk,         // system clock
  input  wire logic                                        rst,         // async reset, high
  input  wire logic                                        rm,          // bench: remove one recording
  output logic                                             an_tick,     // 64 s/c strobe
  output logic [drc_pkg::N_AN_SRC-1:0][drc_pkg::AN_W-1:0]  an_in,       // measurements
  output logic [drc_pkg::N_DIG-1:0]                        dig_in,      // digital signals
  output logic                                             xfer_remove  // pulse: one taken away
);
  import drc_pkg::*;
  // ==========================================================
  // front-end: fixed values so stored words can be predicted
  int cnt;
  always_comb begin
    for (int i = 0; i < N_AN_SRC; i++) an_in[i] = 16'(16'h0101 * i);
  end
  assign dig_in = {3'h5, {23{4'hA}}};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt         <= 0;
      an_tick     <= 1'b0;
      xfer_remove <= 1'b0;
    end else begin
      cnt         <= (cnt == AP - 1) ? 0 : cnt + 1;
      an_tick     <= (cnt == AP - 1);
      // client removal follows the bench rm input one cycle later, whatever the area holds
      xfer_remove <= rm;
    end
  end
endmodule : drc_partner
`default_nettype wire

// [sim/testbench.sv]
// testbench: directed checks of the capture engine through its ports
// assumes drc_pkg, drc_capture and drc_partner are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import drc_pkg::*;
  localparam int DC = 50;   // shortened 5 ms
  localparam int AP = 10;
  // ==========================================================
  // signals
  logic                          clk = 1'b0, rst = 1'b1, cfg_load = 1'b0, manual_trig = 1'b0;
  logic                          get_req = 1'b0, rm = 1'b0;
  logic [20:0]                   max_len = '0;
  logic [6:0]                    max_recs = 7'h02, get_idx = '0, get_slot;
  logic [N_TRIG-1:0]             trig_in = '0;
  logic                          an_tick, samp_we, xfer_push, rec_drop, rec_refuse, get_ack, get_ok, xfer_remove;
  logic [N_AN_SRC-1:0][AN_W-1:0] an_in;
  logic [N_DIG-1:0]              dig_in, dg;
  logic [N_AN_SLOT-1:0][AN_W-1:0] av;
  logic [15:0]                   trig_addr;
  drc_cfg_t                      c;
  drc_samp_t                     samp;
  drc_status_t                   status;
  int err_total = 0, comparisons = 0, cyc = 0, last_a = -1, last_d = -1, min_a = 999;
  int n_push = 0, n_drop = 0, n_ref = 0, n_we = 0, n;
  always #5 clk = ~clk;
  drc_capture #(.DIG_CYC(DC), .STEP_CYC(100)) dut (.clk(clk), .rst(rst), .cfg_in(c), .cfg_load(cfg_load),
    .manual_trig(manual_trig), .max_len(max_len), .max_recs(max_recs), .trig_in(trig_in), .an_tick(an_tick),
    .an_in(an_in), .dig_in(dig_in), .get_req(get_req), .get_idx(get_idx), .xfer_remove(xfer_remove),
    .samp(samp), .samp_we(samp_we), .status(status), .trig_addr(trig_addr), .xfer_push(xfer_push),
    .rec_drop(rec_drop), .rec_refuse(rec_refuse), .get_ack(get_ack), .get_ok(get_ok), .get_slot(get_slot));
  drc_partner #(.AP(AP)) fe (.clk(clk), .rst(rst), .rm(rm), .an_tick(an_tick), .an_in(an_in),
    .dig_in(dig_in), .xfer_remove(xfer_remove));
  // ==========================================================
  // tasks
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic fail(input string s);
    err_total++;
    $display("FAIL %0t %s", $time, s);
  endtask : fail
  task automatic chk(input logic [127:0] g, input logic [127:0] e, input string s);
    comparisons++;
    if (g !== e) fail(s);
  endtask : chk
  task automatic load(input drc_cfg_t v);
    c = v;
    cfg_load = 1'b1;
    tick;
    cfg_load = 1'b0;
    tick;  // a sample decided under the old settings is still in flight
    min_a = 999;
    last_a = -1;
    last_d = -1;
  endtask : load
  task automatic rec(input bit pin, output int n);
    if (pin) trig_in[3] = 1'b1;
    else manual_trig = 1'b1;
    tick;
    if (!pin) chk(status.manual_trig, 1, "trigger readback");
    trig_in = '0;
    manual_trig = 1'b0;
    n = 0;
    // a pin edge is taken at once, a manual write one cycle later
    while (status.stat !== DRC_ST_TRIG && n < 4) begin tick; n++; end
    chk(status.stat, DRC_ST_TRIG, "triggered state");
    chk(status.manual_trig, 0, "trigger self clear");
    chk(samp.addr - trig_addr <= 16'h0001, 1, "trigger address");
    n = 0;
    while (status.stat !== DRC_ST_STORE && n < 3000) begin tick; n++; end
    chk(status.stat, DRC_ST_STORE, "storing state");
    repeat (2) tick;
  endtask : rec
  // a trigger that must be ignored
  task automatic quiet(input logic [15:0] t);
    trig_in = t;
    tick;
    trig_in = '0;
    repeat (10) tick;
  endtask : quiet
  task automatic get(input logic [6:0] i, input logic ok, input logic [6:0] sl);
    int w;
    get_idx = i;
    get_req = 1'b1;
    tick;
    get_req = 1'b0;
    w = 0;
    while (get_ack !== 1'b1 && w < 3) begin tick; w++; end
    chk(get_ack, 1, "retrieval answer");
    chk(get_ok, ok, "retrieval held flag");
    if (ok) chk(get_slot, sl, "retrieval slot");
    tick;
  endtask : get
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // ==========================================================
  // monitor: sample spacing and pulse counts
  always @(posedge clk) begin
    cyc++;
    n_push += int'(xfer_push === 1'b1);
    n_drop += int'(rec_drop === 1'b1);
    n_ref += int'(rec_refuse === 1'b1);
    if (samp_we === 1'b1) begin
      n_we++;
      if (samp.is_dig === 1'b1) begin
        if (last_d >= 0) comparisons++;
        if (last_d >= 0 && cyc - last_d != DC) fail("digital period");
        last_d = cyc;
        dg = samp.dig;
      end else begin
        if (last_a >= 0 && cyc - last_a < min_a) min_a = cyc - last_a;
        last_a = cyc;
        av = samp.an;
      end
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail("watchdog");
    stop_test;
  end
  // ==========================================================
  // tests
  initial begin
    c = '0;
    c.pre_steps = 9'h002;
    c.len_steps = 18'h00019;
    c.trig_mask = 16'h0008;  // one source chosen
    c.dig_sel = ~95'h1;
    for (int i = 0; i < 8; i++) begin c.an_en[i] = 1'b1; c.an_src[i] = 5'(2 * i + 5); end
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    chk(status.stat, DRC_ST_BADCFG, "no trigger after reset");
    load(c);
    chk(status.stat, DRC_ST_BADCFG, "zero max length");
    max_len = 21'h003E8;
    tick;
    chk(status.stat, DRC_ST_READY, "ready");
    for (int r = 0; r < 4; r++) begin
      c.rate = 2'(r);
      load(c);
      repeat (400) tick;
      chk(min_a, AP << r, "analog spacing");
    end
    for (int i = 0; i < 8; i++) chk(av[i], (2 * i + 5) * 16'h0101, "analog slot");
    chk(dg, dig_in & c.dig_sel, "digital word");
    $display("test sampling done");
    quiet(16'h0020);
    chk(status.stat, DRC_ST_READY, "unselected source");
    rec(0, n);
    chk(n >= 400 && n <= 505, 1, "post length");
    c.pre_steps = 9'h003;
    load(c);
    rec(1, n);
    chk(n <= 2, 1, "no post span");
    chk(status.rec_cnt, 2, "two stored");
    chk(status.stat, DRC_ST_FULL, "memory full");
    rec(1, n);
    chk(n_drop, 1, "oldest dropped");
    get(1, 1, 2);
    get(2, 0, 0);
    $display("test fifo done");
    c.keep_old = MODE_KEEP;
    load(c);
    quiet(16'h0008);
    chk({status.rec_cnt, n_drop, n_ref}, {7'h02, 32'd1, 32'd0}, "keep refuses");
    chk(status.stat, DRC_ST_FULL, "still full");
    $display("test keep done");
    c.keep_old = MODE_FIFO;
    c.auto_xfer = 1'b1;
    load(c);
    repeat (7) rec(1, n);
    chk(n_push, 6, "six pushed");
    chk(status.xfer_cnt, 6, "area full");
    chk(n_drop, 2, "seventh kept locally");
    get(2, 0, 0);
    rm = 1'b1;
    tick;
    rm = 1'b0;
    repeat (3) tick;
    chk(status.xfer_cnt, 5, "client removed one");
    rec(1, n);
    chk(n_push, 7, "push resumes");
    $display("test transfer done");
    c.rec_dis = 1'b1;
    load(c);
    repeat (2) tick;
    n_we = 0;
    quiet(16'h0008);
    repeat (100) tick;
    chk({n_we, status.stat}, {32'd0, DRC_ST_FULL}, "disabled recorder");
    $display("test disable done");
    stop_test;
  end
endmodule : testbench
`default_nettype wire

// [src/drc_capture.sv]
// drc_capture: disturbance recorder capture engine with recording table and transfer area
// assumes front-end strobes and settings are synchronous to clk; sample memory sits outside
`timescale 1ns/1ps
`default_nettype none
module drc_capture #(
  parameter int unsigned DIG_CYC  = drc_pkg::DIG_CYC,   // 5 ms in clocks
  parameter int unsigned STEP_CYC = drc_pkg::STEP_CYC   // 10 ms in clocks
) (
  input  wire logic                     clk,          // system clock
  input  wire logic                     rst,          // async reset, high
  input  wire drc_pkg::drc_cfg_t        cfg_in,       // new settings
  input  wire logic                     cfg_load,     // pulse: take cfg_in
  input  wire logic                     manual_trig,  // pulse: manual trigger write
  input  wire logic [20:0]              max_len,      // computed max recording length, 0 = none
  input  wire logic [6:0]               max_recs,     // computed recording capacity
  input  wire logic [drc_pkg::N_TRIG-1:0] trig_in,    // trigger sources, level
  input  wire logic                     an_tick,      // front-end 64 s/c strobe
  input  wire logic [drc_pkg::N_AN_SRC-1:0][drc_pkg::AN_W-1:0] an_in, // analog measurements
  input  wire logic [drc_pkg::N_DIG-1:0] dig_in,      // digital signals
  input  wire logic                     get_req,      // pulse: local retrieval request
  input  wire logic [6:0]               get_idx,      // 0 = oldest held locally
  input  wire logic                     xfer_remove,  // pulse: client removed one recording
  output drc_pkg::drc_samp_t            samp,         // sample word for memory
  output logic                          samp_we,      // pulse: write samp
  output drc_pkg::drc_status_t          status,       // recorder state
  output logic [15:0]                   trig_addr,    // sample address at trigger
  output logic                          xfer_push,    // pulse: recording moved to transfer area
  output logic                          rec_drop,     // pulse: oldest slot overwritten
  output logic                          rec_refuse,   // pulse: recording refused
  output logic                          get_ack,      // pulse: retrieval answer
  output logic                          get_ok,       // requested recording held locally
  output logic [6:0]                    get_slot      // physical slot of it
);
  import drc_pkg::*;
  // ==========================================================
  // helpers
  function automatic logic [2:0] rate_mask(input logic [1:0] r);
    rate_mask = 3'((4'h1 << r) - 4'h1);
  endfunction : rate_mask
  function automatic logic [6:0] slot_add(input logic [6:0] a, input logic [6:0] b);
    logic [7:0] s;
    s = {1'b0, a} + {1'b0, b};
    slot_add = (s >= {1'b0, REC_MAX}) ? 7'(s - {1'b0, REC_MAX}) : s[6:0];
  endfunction : slot_add
  // ==========================================================
  // settings, manual trigger
  drc_cfg_t cfg_q, cfg_d;
  logic     man_q, man_d;
  always_comb begin
    cfg_d = cfg_load ? cfg_in : cfg_q;
    man_d = manual_trig;                                          // self-returns next cycle
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q           <= '0;
      cfg_q.rec_dis   <= REC_ENABLED;
      cfg_q.keep_old  <= MODE_FIFO;
      cfg_q.rate      <= RATE_DEF;
      cfg_q.pre_steps <= PRE_DEF;
      cfg_q.len_steps <= LEN_DEF;
      cfg_q.auto_xfer <= AUTO_XFER_DEF;
      man_q           <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      man_q <= man_d;
    end
  end

  // ==========================================================
  // time bases
  logic dig_tick, step_tick;
  drc_tick #(.PERIOD(DIG_CYC)) u_dig_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (dig_tick)
  );
  drc_tick #(.PERIOD(STEP_CYC)) u_step_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (step_tick)
  );

  // ==========================================================
  // continuous sampling into the circular sample area
  logic       run;
  logic [2:0] ph_q, ph_d;
  logic       an_take;
  drc_samp_t  samp_q, samp_d;
  logic       we_q, we_d;
  assign run     = (cfg_q.rec_dis == REC_ENABLED);
  assign an_take = an_tick && ((ph_q & rate_mask(cfg_q.rate)) == 3'h0);
  always_comb begin
    ph_d   = an_tick ? ((ph_q == AN_PH_MAX) ? 3'h0 : ph_q + 3'h1) : ph_q;
    samp_d = samp_q;
    we_d   = 1'b0;
    // digital strobe wins a clash; the analog strobe is rare enough to lose one point
    if (run && dig_tick) begin
      we_d        = 1'b1;
      samp_d.is_dig = 1'b1;
      samp_d.dig  = dig_in & cfg_q.dig_sel;
      samp_d.addr = samp_q.addr + 16'h0001;
    end else if (run && an_take) begin
      we_d          = 1'b1;
      samp_d.is_dig = 1'b0;
      samp_d.addr   = samp_q.addr + 16'h0001;
      for (int i = 0; i < N_AN_SLOT; i++) begin
        samp_d.an[i] = (cfg_q.an_en[i] && cfg_q.an_src[i] < 5'(N_AN_SRC))
                     ? an_in[cfg_q.an_src[i]] : '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_q   <= 3'h0;
      samp_q <= '0;
      we_q   <= 1'b0;
    end else begin
      ph_q   <= ph_d;
      samp_q <= samp_d;
      we_q   <= we_d;
    end
  end

  assign samp    = samp_q;
  assign samp_we = we_q;
  // ==========================================================
  // capture sequence
  drc_state_t  st_q, st_d;
  logic [11:0] pre_lim, pre_q, pre_d;
  logic [18:0] post_len;
  logic [17:0] post_q, post_d;
  logic [15:0] taddr_q, taddr_d;
  logic [N_TRIG-1:0] trg_q;
  logic        trg_rise, cfg_bad, is_full, xfer_room, keep_block;
  logic [6:0]  cnt_q, cnt_d, old_q, old_d;
  logic [2:0]  xc_q, xc_d;
  logic        push_d, drop_d, ref_d, push_q, drop_q, ref_q;
  assign pre_lim    = 12'(cfg_q.pre_steps * PRE_UNIT);
  assign post_len   = {1'b0, cfg_q.len_steps} - {7'h00, pre_lim};
  assign trg_rise   = |(trig_in & ~trg_q & cfg_q.trig_mask);
  assign cfg_bad    = (max_len == 21'h000000) || (cfg_q.trig_mask == '0);
  assign is_full    = (cnt_q >= max_recs);
  assign xfer_room  = cfg_q.auto_xfer && (xc_q < XFER_MAX);
  assign keep_block = (cfg_q.keep_old == MODE_KEEP) && is_full && !xfer_room;
  always_comb begin
    st_d    = st_q;
    pre_d   = pre_q;
    post_d  = post_q;
    taddr_d = taddr_q;
    cnt_d   = cnt_q;
    old_d   = old_q;
    push_d  = 1'b0;
    drop_d  = 1'b0;
    ref_d   = 1'b0;
    // pre window fills in every state but S_COMMIT, which clears it, saturating at the set span
    if (step_tick && pre_q < pre_lim) begin
      pre_d = pre_q + 12'h001;
    end
    if (pre_q > pre_lim) begin
      pre_d = pre_lim;
    end
    unique case (st_q)
      S_IDLE: begin
        if (run && !cfg_bad && (trg_rise || man_q) && !keep_block) begin
          st_d    = S_TRIG;
          taddr_d = samp_q.addr;
        end
      end
      S_TRIG: begin
        st_d   = (post_len[18] || post_len == 19'h00000) ? S_COMMIT : S_POST;
        post_d = post_len[17:0];
      end
      S_POST: begin
        if (step_tick) begin
          post_d = post_q - 18'h00001;
          if (post_q == 18'h00001) begin
            st_d = S_COMMIT;
          end
        end
      end
      S_COMMIT: begin
        st_d  = S_IDLE;
        pre_d = 12'h000;                                          // next pre window starts afresh
        if (xfer_room) begin
          push_d = 1'b1;                                          // not entered locally
        end else if (!is_full) begin
          cnt_d = cnt_q + 7'h01;
        end else if (cfg_q.keep_old == MODE_FIFO) begin
          old_d  = slot_add(old_q, 7'h01);
          drop_d = 1'b1;
        end else begin
          ref_d = 1'b1;                                           // stored ones untouched
        end
      end
    endcase
    // capacity lowered below the held count, but not to 0: shed the newest ones
    if (cnt_d > max_recs && max_recs != 7'h00) begin
      cnt_d = max_recs;
    end
  end
  // transfer area count: client removal and push may coincide
  always_comb begin
    xc_d = xc_q;
    if (push_d) begin
      xc_d = xc_d + 3'h1;
    end
    if (xfer_remove && xc_q != 3'h0) begin
      xc_d = xc_d - 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q    <= S_IDLE;
      pre_q   <= 12'h000;
      post_q  <= 18'h00000;
      taddr_q <= 16'h0000;
      trg_q   <= '0;
      cnt_q   <= 7'h00;
      old_q   <= 7'h00;
      xc_q    <= 3'h0;
      push_q  <= 1'b0;
      drop_q  <= 1'b0;
      ref_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      pre_q   <= pre_d;
      post_q  <= post_d;
      taddr_q <= taddr_d;
      trg_q   <= trig_in;
      cnt_q   <= cnt_d;
      old_q   <= old_d;
      xc_q    <= xc_d;
      push_q  <= push_d;
      drop_q  <= drop_d;
      ref_q   <= ref_d;
    end
  end

  assign trig_addr  = taddr_q;
  assign xfer_push  = push_q;
  assign rec_drop   = drop_q;
  assign rec_refuse = ref_q;
  // ==========================================================
  // status and local retrieval
  drc_stat_t stat_d;
  logic      ack_q, ok_q, ok_d;
  logic [6:0] slot_q, slot_d;
  always_comb begin
    unique case (st_q)
      S_TRIG:   stat_d = DRC_ST_TRIG;
      S_POST:   stat_d = DRC_ST_RECSTORE;
      S_COMMIT: stat_d = DRC_ST_STORE;
      S_IDLE:   stat_d = cfg_bad ? DRC_ST_BADCFG :
                         (is_full ? DRC_ST_FULL : DRC_ST_READY);
    endcase
    ok_d   = get_idx < cnt_q;                                     // only local recordings
    slot_d = slot_add(old_q, get_idx);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q  <= 1'b0;
      ok_q   <= 1'b0;
      slot_q <= 7'h00;
    end else begin
      ack_q  <= get_req;
      ok_q   <= get_req ? ok_d : ok_q;
      slot_q <= get_req ? slot_d : slot_q;
    end
  end

  assign status.stat        = stat_d;
  assign status.rec_cnt     = cnt_q;
  assign status.xfer_cnt    = xc_q;
  assign status.manual_trig = man_q;
  assign get_ack            = ack_q;
  assign get_ok             = ok_q;
  assign get_slot           = slot_q;
  // ==========================================================
  // checks; the digital period check sits in the divider itself
  keep_refuse_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == S_COMMIT && !xfer_room && is_full && cfg_q.keep_old == MODE_KEEP)
      |=> rec_refuse && $stable(old_q))
    else $error("full keep policy did not refuse");
  fifo_drop_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == S_COMMIT && !xfer_room && is_full && cfg_q.keep_old == MODE_FIFO && max_recs == cnt_q)
      |=> rec_drop && old_q != $past(old_q))
    else $error("fifo policy did not drop oldest");
  rate_dec_a: assert property (@(posedge clk) disable iff (rst)
    (an_take && cfg_q.rate == 2'h3) |-> ph_q == 3'h0)
    else $error("8 s/c sample off phase");
  pre_bound_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == S_IDLE && step_tick && pre_q < pre_lim && !cfg_load) |=> pre_q == $past(pre_q) + 12'h001)
    else $error("pre window not filling");
  xfer_cap_a: assert property (@(posedge clk) disable iff (rst)
    xc_q <= XFER_MAX)
    else $error("transfer area above six");
  xfer_local_a: assert property (@(posedge clk) disable iff (rst)
    xfer_push |-> $stable(cnt_q) && $past(cfg_q.auto_xfer))
    else $error("pushed recording also held locally");
  not_ready_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == S_IDLE && max_len == 21'h000000) |-> status.stat == DRC_ST_BADCFG ##1 st_q == S_IDLE)
    else $error("ready with zero max length");
  man_pulse_a: assert property (@(posedge clk) disable iff (rst)
    (manual_trig ##1 !manual_trig) |-> man_q ##1 !man_q)
    else $error("manual trigger did not self-return");
  off_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (cfg_q.rec_dis != REC_ENABLED) |=> !samp_we)
    else $error("disabled recorder sampled");

  trig_run_c: cover property (@(posedge clk) disable iff (rst) st_q == S_TRIG ##1 st_q == S_POST);
  push_c:     cover property (@(posedge clk) disable iff (rst) xfer_push);
  drop_c:     cover property (@(posedge clk) disable iff (rst) rec_drop);
  refuse_c:   cover property (@(posedge clk) disable iff (rst) rec_refuse);

endmodule : drc_capture
`default_nettype wire

// [src/drc_pkg.sv]
// disturbance recorder capture: shared constants, types and defaults
// assumes a single 100 MHz clock domain
`default_nettype none
package drc_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned DIG_PERIOD_MS = 5;                          // digital sample period, fixed
  localparam int unsigned STEP_MS       = 10;                         // length step, 0.01 s
  localparam int unsigned DIG_CYC       = CLK_HZ / 1000 * DIG_PERIOD_MS;
  localparam int unsigned STEP_CYC      = CLK_HZ / 1000 * STEP_MS;
  localparam logic [3:0]  PRE_UNIT      = 4'hA;                       // 0.1 s pre step in 0.01 s steps

  // ==========================================================
  // sizes
  localparam int unsigned N_AN_SLOT = 8;                              // selectable analog slots
  localparam int unsigned N_AN_SRC  = 20;                             // analog measurements on offer
  localparam int unsigned N_DIG     = 95;                             // selectable digital signals
  localparam int unsigned AN_W      = 16;
  localparam int unsigned N_TRIG    = 16;
  localparam logic [6:0]  REC_MAX   = 7'h64;                          // recording slots, 100
  localparam logic [2:0]  XFER_MAX  = 3'h6;                           // transfer area depth
  localparam logic [2:0]  AN_PH_MAX = 3'h7;                           // 64 s/c strobe phase wrap

  // ==========================================================
  // setting codes and defaults
  localparam logic        REC_ENABLED   = 1'h0;
  localparam logic        MODE_FIFO     = 1'h0;
  localparam logic        MODE_KEEP     = 1'h1;
  localparam logic [1:0]  RATE_DEF      = 2'h0;                       // 64 samples per cycle
  localparam logic [8:0]  PRE_DEF       = 9'h002;                     // 0.2 s
  localparam logic [17:0] LEN_DEF       = 18'h00064;                  // 1 s in 0.01 s steps
  localparam logic        AUTO_XFER_DEF = 1'h0;

  typedef enum logic [2:0] {
    DRC_ST_READY = 3'h0, DRC_ST_TRIG = 3'h1, DRC_ST_RECSTORE = 3'h2,
    DRC_ST_STORE = 3'h3, DRC_ST_FULL = 3'h4, DRC_ST_BADCFG = 3'h5
  } drc_stat_t;

  typedef enum {S_IDLE, S_TRIG, S_POST, S_COMMIT} drc_state_t;

  typedef struct packed {
    logic                        rec_dis;      // 0 enables the recorder
    logic                        keep_old;     // full-memory policy
    logic [1:0]                  rate;         // analog samples per cycle code
    logic [8:0]                  pre_steps;    // pre-trigger span, 0.1 s units
    logic [17:0]                 len_steps;    // total length, 0.01 s units
    logic                        auto_xfer;
    logic [N_AN_SLOT-1:0]        an_en;
    logic [N_AN_SLOT-1:0][4:0]   an_src;
    logic [N_DIG-1:0]            dig_sel;
    logic [N_TRIG-1:0]           trig_mask;
  } drc_cfg_t;

  typedef struct packed {
    logic                        is_dig;
    logic [15:0]                 addr;
    logic [N_AN_SLOT-1:0][AN_W-1:0] an;
    logic [N_DIG-1:0]            dig;
  } drc_samp_t;

  typedef struct packed {
    drc_stat_t                   stat;
    logic [6:0]                  rec_cnt;
    logic [2:0]                  xfer_cnt;
    logic                        manual_trig;  // reads back 1 for one cycle only
  } drc_status_t;

endpackage : drc_pkg
`default_nettype wire

// [src/drc_tick.sv]
// drc_tick: free running divider giving a one-cycle pulse every PERIOD clocks
// assumes PERIOD fits in 24 bits
`timescale 1ns/1ps
`default_nettype none
module drc_tick #(
  parameter int unsigned PERIOD = 16
) (
  input  wire logic clk,   // system clock
  input  wire logic rst,   // async reset, high
  output logic      tick   // one-cycle pulse
);
  logic [23:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = (cnt_q == 24'(PERIOD - 1)) ? 24'h000000 : cnt_q + 24'h000001;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 24'h000000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = (cnt_q == 24'(PERIOD - 1));

  // ==========================================================
  // checks: gap counter saturates, so the first pulse after reset has no false predecessor
  logic [23:0] gap_q, gap_d;

  always_comb begin
    gap_d = tick ? 24'h000001 : ((gap_q == 24'hFFFFFF) ? gap_q : gap_q + 24'h000001);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q <= 24'hFFFFFF;
    end else begin
      gap_q <= gap_d;
    end
  end

  tick_gap_a: assert property (@(posedge clk) disable iff (rst)
    tick |-> gap_q >= 24'(PERIOD))
    else $error("pulse spacing shorter than the set period");
endmodule : drc_tick
`default_nettype wire
